/* File: verilog/pcm_top.sv */
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// R1: Mask register shows enabled sources at bits 0,1,3,8,9,16,17,18.
// R2: Enable writes set mask bits, disable writes clear them, zeros ignored.
// R3: Clock fail event bit sticks until status register read.
// R4: Interrupt output high while any status bit and mask bit both set.
// R5: Software programs pump current field from PLL electrical figures.
// R6: Mode write with enable one and correct key turns guard on.
// R7: Mode write with enable zero and correct key turns guard off.
// R8: Wrong key leaves guard enable unchanged.
// R9: Key field always reads zero.
// R10: Guard covers clock enable/disable, main freq, PLL, master, USB, prog, pump.
// R11: Guarded write leaves register unchanged and counts as violation.
// R12: Violation bit set on violation, held until report read.
// R13: Violation source reports offset of targeted register.
// R14: Reading report clears flag and source.
// R15: Nonzero divisor only for indexes 2,3,5-11,13-19,28-30.
// R16: Divisor codes 0..3 give master clock /1,/2,/4,/8.
// R17: Write mode with enable one turns selected peripheral clock on.
// R18: Write mode with enable zero stops selected peripheral clock.
// R19: Command bit one applies settings; zero only selects for reads.
module pcm_top #(
  parameter int NUM_PERIPH = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [31:0] clk_status_in,
  input wire logic clock_fail_detect,
  output logic irq,
  output logic guard_on,
  output logic [31:0] sys_clk_en,
  output logic [31:0] main_freq_cfg,
  output logic [31:0] first_pll_cfg,
  output logic [31:0] master_clock_cfg,
  output logic [31:0] usb_clk_cfg,
  output logic [63:0] prog_clk_cfg,
  output logic [31:0] pump_current_sel,
  output logic [NUM_PERIPH-1:0] periph_en,
  output logic [2*NUM_PERIPH-1:0] periph_div
);
  import pcm_pkg::*;

  // ----------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------
  pcm_req_t req_reg;
  pcm_req_t req_next;
  wire addr_ok = (haddr[31:9] == 23'h0) && (haddr[1:0] == 2'b00);
  assign req_next = '{valid: hsel && hready && htrans[1] && addr_ok,
                      write: hwrite, addr: haddr[8:0]};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_reg <= '0;
    end else if (clk_en) begin
      req_reg <= req_next;
    end
  end

  // Zero wait states keep the slave simple; all answers are OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  wire wr = req_reg.valid && req_reg.write;
  wire rd = req_reg.valid && !req_reg.write;
  wire hi = req_reg.addr[8];
  wire [7:0] a = req_reg.addr[7:0];
  wire blocked;
  wire [31:0] report_rdata;
  wire [31:0] pctl_rdata;

  // R11: covered write suppressed
  wire wr_ok = wr && !blocked && !hi;
  wire wr_ier = wr_ok && (a == OFS_IER);
  wire wr_idr = wr_ok && (a == OFS_IDR);
  wire rd_sr = rd && !hi && (a == OFS_SR);
  wire wr_pctl = wr && hi && (a == OFS_PCTL[7:0]);

  // ----------------------------------------------------------------
  // Write protection and peripheral clocks
  // ----------------------------------------------------------------
  pcm_guard u_guard (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .req(req_reg),
    .wdata(hwdata),
    .guard_on(guard_on),
    .blocked(blocked),
    .report_rdata(report_rdata)
  );

  pcm_periph_clk #(.NUM_PERIPH(NUM_PERIPH)) u_pclk (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .wr(wr_pctl),
    .wdata(hwdata),
    .rdata(pctl_rdata),
    .periph_en(periph_en),
    .periph_div(periph_div)
  );

  // ----------------------------------------------------------------
  // Guarded clock configuration registers
  // ----------------------------------------------------------------
  logic [31:0] scsr_reg;
  logic [31:0] mcfr_reg;
  logic [31:0] first_pll_reg;
  logic [31:0] mckr_reg;
  logic [31:0] usb_reg;
  logic [31:0] pck0_reg;
  logic [31:0] pck1_reg;
  logic [31:0] pump_reg;

  // R10: guarded registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scsr_reg <= RESET_ZERO;
      mcfr_reg <= RESET_ZERO;
      first_pll_reg <= RESET_FIRST_PLL;
      mckr_reg <= RESET_MCKR;
      usb_reg <= RESET_ZERO;
      pck0_reg <= RESET_ZERO;
      pck1_reg <= RESET_ZERO;
      pump_reg <= RESET_ZERO;
    end else if (clk_en && wr_ok) begin
      if (a == OFS_SCER) begin
        scsr_reg <= scsr_reg | hwdata;
      end else if (a == OFS_SCDR) begin
        scsr_reg <= scsr_reg & ~hwdata;
      end else if (a == OFS_MCFR) begin
        mcfr_reg <= hwdata;
      end else if (a == OFS_FIRST_PLL) begin
        first_pll_reg <= hwdata;
      end else if (a == OFS_MCKR) begin
        mckr_reg <= hwdata;
      end else if (a == OFS_USB) begin
        usb_reg <= hwdata;
      end else if (a == OFS_PCK0) begin
        pck0_reg <= hwdata;
      end else if (a == OFS_PCK1) begin
        pck1_reg <= hwdata;
      end else if (a == OFS_PUMP) begin
        // R5: only bit 0 of the pump field is stored, upper bits cleared
        pump_reg <= {31'h0, hwdata[0]};
      end
    end
  end

  assign sys_clk_en = scsr_reg;
  assign main_freq_cfg = mcfr_reg;
  assign first_pll_cfg = first_pll_reg;
  assign master_clock_cfg = mckr_reg;
  assign usb_clk_cfg = usb_reg;
  assign prog_clk_cfg = {pck1_reg, pck0_reg};
  assign pump_current_sel = pump_reg;

  // ----------------------------------------------------------------
  // Status, mask and interrupt
  // ----------------------------------------------------------------
  logic [31:0] mask_reg;
  logic [31:0] mask_next;
  logic cfev_reg;

  // R2: set and clear by separate writes
  assign mask_next = wr_ier ? (mask_reg | (hwdata & IRQ_SRC_MASK)) :
                     wr_idr ? (mask_reg & ~hwdata) : mask_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_reg <= RESET_ZERO;
    end else if (clk_en) begin
      mask_reg <= mask_next;
    end
  end

  // R3: sticky fail event, set beats read clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfev_reg <= 1'b0;
    end else if (clk_en && clock_fail_detect) begin
      cfev_reg <= 1'b1;
    end else if (clk_en && rd_sr) begin
      cfev_reg <= 1'b0;
    end
  end

  wire [31:0] status = ((clk_status_in & IRQ_SRC_MASK) & ~(32'h1 << BIT_CLOCK_FAIL_EVENT)) |
                       ({31'h0, cfev_reg} << BIT_CLOCK_FAIL_EVENT);

  // R4: level interrupt
  assign irq = |(status & mask_reg);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // R1: mask readback
  wire [31:0] rmux = hi ? ((a == OFS_PCTL[7:0]) ? pctl_rdata : 32'h0) :
                     (a == OFS_SCSR) ? scsr_reg :
                     (a == OFS_MCFR) ? mcfr_reg :
                     (a == OFS_FIRST_PLL) ? first_pll_reg :
                     (a == OFS_MCKR) ? mckr_reg :
                     (a == OFS_USB) ? usb_reg :
                     (a == OFS_PCK0) ? pck0_reg :
                     (a == OFS_PCK1) ? pck1_reg :
                     (a == OFS_SR) ? status :
                     (a == OFS_IMR) ? (mask_reg & IRQ_SRC_MASK) :
                     (a == OFS_GUARD_MODE) ? {31'h0, guard_on} :
                     (a == OFS_GUARD_REPORT) ? report_rdata : 32'h0;
  assign hrdata = rd ? rmux : 32'h0;

  property p_irq;
    @(posedge hclk) disable iff (!hresetn) irq == |(status & mask_reg);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch"); // R4

  property p_ier;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && wr_ier && hwdata[0]) |=> mask_reg[0];
  endproperty
  a_ier: assert property (p_ier) else $error("enable did not set mask"); // R2

  property p_cfev;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && clock_fail_detect) |=> cfev_reg;
  endproperty
  a_cfev: assert property (p_cfev) else $error("fail event lost"); // R3

  property p_guarded;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && blocked && a == OFS_MCKR) |=> $stable(mckr_reg);
  endproperty
  a_guarded: assert property (p_guarded) else $error("guarded write landed"); // R11

  property p_imr_res;
    @(posedge hclk) disable iff (!hresetn) (mask_reg & ~IRQ_SRC_MASK) == 32'h0;
  endproperty
  a_imr_res: assert property (p_imr_res) else $error("reserved mask bit"); // R1

  property p_imr_read;
    @(posedge hclk) disable iff (!hresetn)
      (rd && !hi && a == OFS_IMR) |-> ((hrdata & ~IRQ_SRC_MASK) == 32'h0);
  endproperty
  a_imr_read: assert property (p_imr_read) else $error("mask read shows reserved bit"); // R1

  property p_ier_all;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && wr_ier) |=> ((mask_reg & $past(hwdata) & IRQ_SRC_MASK) ==
                              ($past(hwdata) & IRQ_SRC_MASK));
  endproperty
  a_ier_all: assert property (p_ier_all) else $error("enable write missed a bit"); // R2

  property p_idr;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && wr_idr && hwdata[18]) |=> !mask_reg[18];
  endproperty
  a_idr: assert property (p_idr) else $error("disable did not clear mask"); // R2

  property p_cfev_clear;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && rd_sr && !clock_fail_detect) |=> !cfev_reg;
  endproperty
  a_cfev_clear: assert property (p_cfev_clear) else $error("fail event not cleared"); // R3

  property p_cfev_hold;
    @(posedge hclk) disable iff (!hresetn)
      (cfev_reg && !(clk_en && rd_sr)) |=> cfev_reg;
  endproperty
  a_cfev_hold: assert property (p_cfev_hold) else $error("fail event dropped early"); // R3

  property p_irq_fail;
    @(posedge hclk) disable iff (!hresetn)
      (cfev_reg && mask_reg[BIT_CLOCK_FAIL_EVENT]) |-> irq;
  endproperty
  a_irq_fail: assert property (p_irq_fail) else $error("fail event irq missing"); // R4

  property p_guarded_scsr;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && blocked && (a == OFS_SCER || a == OFS_SCDR)) |=> $stable(scsr_reg);
  endproperty
  a_guarded_scsr: assert property (p_guarded_scsr) else $error("guarded enable landed"); // R10

  property p_guarded_pump;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && blocked && a == OFS_PUMP) |=> $stable(pump_reg);
  endproperty
  a_guarded_pump: assert property (p_guarded_pump) else $error("guarded pump landed"); // R11

  property p_open_write;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && wr && !guard_on && !hi && a == OFS_MCFR) |=> (mcfr_reg == $past(hwdata));
  endproperty
  a_open_write: assert property (p_open_write) else $error("open write lost"); // R11
endmodule

/* File: verilog/pcm_pkg.sv */
package pcm_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SCER = 8'h00;
  localparam logic [7:0] OFS_SCDR = 8'h04;
  localparam logic [7:0] OFS_SCSR = 8'h08;
  localparam logic [7:0] OFS_MCFR = 8'h24;
  localparam logic [7:0] OFS_FIRST_PLL = 8'h28;
  localparam logic [7:0] OFS_MCKR = 8'h30;
  localparam logic [7:0] OFS_USB = 8'h38;
  localparam logic [7:0] OFS_PCK0 = 8'h40;
  localparam logic [7:0] OFS_PCK1 = 8'h44;
  localparam logic [7:0] OFS_IER = 8'h60;
  localparam logic [7:0] OFS_IDR = 8'h64;
  localparam logic [7:0] OFS_SR = 8'h68;
  localparam logic [7:0] OFS_IMR = 8'h6C;
  localparam logic [7:0] OFS_PUMP = 8'h80;
  localparam logic [7:0] OFS_GUARD_MODE = 8'hE4;
  localparam logic [7:0] OFS_GUARD_REPORT = 8'hE8;
  localparam logic [8:0] OFS_PCTL = 9'h10C;

  // ----------------------------------------------------------------
  // Field positions and constants
  // ----------------------------------------------------------------
  localparam logic [31:0] IRQ_SRC_MASK = 32'h0007030B;
  localparam int BIT_CLOCK_FAIL_EVENT = 18;
  localparam logic [23:0] GUARD_KEY_VALUE = 24'h504D43;
  localparam int GUARD_KEY_LSB = 8;
  localparam int PCTL_INDEX_LSB = 0;
  localparam int PCTL_CMD_BIT = 12;
  localparam int PCTL_DIV_LSB = 16;
  localparam int PCTL_EN_BIT = 28;
  localparam logic [31:0] DIV_CAPABLE = 32'h700FEFEC;
  localparam logic [31:0] RESET_ZERO = 32'h00000000;
  localparam logic [31:0] RESET_FIRST_PLL = 32'h00003F00;
  localparam logic [31:0] RESET_MCKR = 32'h00000001;

  typedef struct packed {
    logic valid;
    logic write;
    logic [8:0] addr;
  } pcm_req_t;

endpackage

/* File: verilog/pcm_guard.sv */
`timescale 1ns/1ps
module pcm_guard (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire pcm_pkg::pcm_req_t req,
  input wire logic [31:0] wdata,
  output logic guard_on,
  output logic blocked,
  output logic [31:0] report_rdata
);
  import pcm_pkg::*;

  logic guard_on_reg;
  logic viol_reg;
  logic [15:0] src_reg;
  wire wr = req.valid && req.write;
  wire covered = (req.addr[7:0] == OFS_SCER) || (req.addr[7:0] == OFS_SCDR) ||
                 (req.addr[7:0] == OFS_MCFR) || (req.addr[7:0] == OFS_FIRST_PLL) ||
                 (req.addr[7:0] == OFS_MCKR) || (req.addr[7:0] == OFS_USB) ||
                 (req.addr[7:0] == OFS_PCK0) || (req.addr[7:0] == OFS_PCK1) ||
                 (req.addr[7:0] == OFS_PUMP);
  wire is_mode = (req.addr[7:0] == OFS_GUARD_MODE) && !req.addr[8];
  wire rd_report = req.valid && !req.write && (req.addr[7:0] == OFS_GUARD_REPORT) &&
                   !req.addr[8];
  wire key_ok = (wdata[31:GUARD_KEY_LSB] == GUARD_KEY_VALUE);

  // R11: covered write blocked
  assign blocked = wr && guard_on_reg && covered && !req.addr[8];
  assign guard_on = guard_on_reg;
  // R9: key reads zero
  assign report_rdata = {8'h00, src_reg, 7'h00, viol_reg};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      guard_on_reg <= 1'b0;
    // R6: R7: R8: key-guarded update
    end else if (clk_en && wr && is_mode && key_ok) begin
      guard_on_reg <= wdata[0];
    end
  end

  // R12: R13: R14: violation set wins over read clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      viol_reg <= 1'b0;
      src_reg <= 16'h0000;
    end else if (clk_en && blocked) begin
      viol_reg <= 1'b1;
      src_reg <= {8'h00, req.addr[7:0]};
    end else if (clk_en && rd_report) begin
      viol_reg <= 1'b0;
      src_reg <= 16'h0000;
    end
  end

  property p_blocked_sets;
    @(posedge hclk) disable iff (!hresetn) (clk_en && blocked) |=> viol_reg;
  endproperty
  a_blocked_sets: assert property (p_blocked_sets) else $error("violation not set"); // R12

  property p_src;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && blocked) |=> (src_reg[7:0] == $past(req.addr[7:0]));
  endproperty
  a_src: assert property (p_src) else $error("bad violation source"); // R13

  property p_read_clear;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && rd_report && !blocked) |=> (!viol_reg && src_reg == 16'h0000);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("report not cleared"); // R14

  property p_bad_key;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && wr && is_mode && !key_ok) |=> $stable(guard_on_reg);
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("guard changed on bad key"); // R8

  property p_good_key;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && wr && is_mode && key_ok) |=> (guard_on_reg == $past(wdata[0]));
  endproperty
  a_good_key: assert property (p_good_key) else $error("guard not updated"); // R6
endmodule

/* File: verilog/pcm_periph_clk.sv */
`timescale 1ns/1ps
module pcm_periph_clk #(
  parameter int NUM_PERIPH = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic wr,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata,
  output logic [NUM_PERIPH-1:0] periph_en,
  output logic [2*NUM_PERIPH-1:0] periph_div
);
  import pcm_pkg::*;

  logic [5:0] sel_reg;
  wire [5:0] idx = wdata[PCTL_INDEX_LSB +: 6];
  wire cmd = wdata[PCTL_CMD_BIT];
  wire [1:0] div_in = wdata[PCTL_DIV_LSB +: 2];
  wire en_in = wdata[PCTL_EN_BIT];
  wire sel_ok = (sel_reg < 6'(NUM_PERIPH));
  wire [4:0] sel5 = sel_reg[4:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_reg <= 6'h00;
    // R19: every write selects
    end else if (clk_en && wr) begin
      sel_reg <= idx;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PERIPH; g++) begin : g_per
      logic en_reg;
      logic [1:0] div_reg;
      wire hit = clk_en && wr && cmd && (idx == 6'(g));
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          en_reg <= 1'b0;
          div_reg <= 2'h0;
        end else if (hit) begin
          // R17: R18: enable bit drives clock
          en_reg <= en_in;
          // R15: R16: divisor only where capable
          div_reg <= DIV_CAPABLE[g] ? div_in : 2'h0;
        end
      end
      assign periph_en[g] = en_reg;
      assign periph_div[2*g +: 2] = div_reg;
    end
  endgenerate

  assign rdata = sel_ok ? {3'h0, periph_en[sel5], 10'h000, periph_div[2*sel5 +: 2],
                           10'h000, sel_reg} : {26'h0, sel_reg};

  property p_no_div;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && wr && cmd && idx == 6'h00) |=> (periph_div[1:0] == 2'h0);
  endproperty
  a_no_div: assert property (p_no_div) else $error("divisor on fixed peripheral"); // R15

  property p_en;
    @(posedge hclk) disable iff (!hresetn)
      (clk_en && wr && cmd && idx == 6'h02) |=> (periph_en[2] == $past(en_in));
  endproperty
  a_en: assert property (p_en) else $error("enable not applied"); // R17
endmodule

/* File: verification/pcm_top_bench.sv */
`timescale 1ns/1ps
module pcm_top_bench;
  import pcm_pkg::*;

  // ----------------------------------------------------------------
  // Clock, reset and bus signals
  // ----------------------------------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] clk_status_in = 32'h0;
  logic clock_fail_detect = 1'b0;
  logic clk_en = 1'b1;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic irq;
  wire logic guard_on;
  wire logic [31:0] sys_clk_en, main_freq_cfg, first_pll_cfg, master_clock_cfg;
  wire logic [31:0] usb_clk_cfg, pump_current_sel;
  wire logic [63:0] prog_clk_cfg;
  wire logic [31:0] periph_en;
  wire logic [63:0] periph_div;
  int n_mismatch = 0;
  int compares = 0;
  logic [31:0] rd;

  always #25 hclk = ~hclk;

  // The single slave's ready is fed straight back as the bus ready.
  pcm_top dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .clk_status_in(clk_status_in),
    .clock_fail_detect(clock_fail_detect), .irq(irq), .guard_on(guard_on),
    .sys_clk_en(sys_clk_en), .main_freq_cfg(main_freq_cfg), .first_pll_cfg(first_pll_cfg),
    .master_clock_cfg(master_clock_cfg), .usb_clk_cfg(usb_clk_cfg),
    .prog_clk_cfg(prog_clk_cfg), .pump_current_sel(pump_current_sel),
    .periph_en(periph_en), .periph_div(periph_div));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    if (n_mismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Ready and read data are taken at the rising edge, before that edge's updates land.
  task automatic wait_ready(output logic [31:0] r);
    int k;
    logic rdy;
    k = 0;
    do begin
      @(posedge hclk);
      rdy = hreadyout;
      r = hrdata;
      k++;
    end while (rdy !== 1'b1 && k < 100);
    if (rdy !== 1'b1) begin
      n_mismatch++;
    end
  endtask

  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r);
    logic [31:0] dummy;
    @(posedge hclk);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    wait_ready(dummy);
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready(r);
    // Let the end edge's register updates settle before the caller looks at outputs.
    #1;
  endtask

  task automatic wr32(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rd32(input logic [31:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h0, r);
  endtask

  function automatic logic can_div(int i);
    return (i == 2 || i == 3 || (i >= 5 && i <= 11) || (i >= 13 && i <= 19) ||
      (i >= 28 && i <= 30));
  endfunction

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] gofs [9];
    int idx [16];
    logic [1:0] dv;
    logic [31:0] pw;
    gofs = '{32'h00, 32'h04, 32'h24, 32'h28, 32'h30, 32'h38, 32'h40, 32'h44, 32'h80};
    idx = '{0, 1, 2, 3, 4, 5, 6, 11, 12, 13, 19, 20, 27, 28, 30, 31};
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    chk(first_pll_cfg, 32'h00003F00);
    chk(master_clock_cfg, 32'h1);
    chk({guard_on, irq, hresp}, 3'b000);
    // Mask register: set, clear, read-only and unmapped places.
    wr32(32'h60, 32'hFFFFFFFF);
    rd32(32'h6C, rd); chk(rd, 32'h0007030B);
    wr32(32'h64, 32'h00000003);
    wr32(32'h6C, 32'hFFFFFFFF);
    rd32(32'h6C, rd); chk(rd, 32'h00070308);
    rd32(32'hF0, rd); chk(rd, 32'h0);
    // Interrupt line and sticky clock failure event.
    @(posedge hclk) clk_status_in <= 32'h1;
    repeat (2) @(posedge hclk);
    chk(irq, 1'b0);
    wr32(32'h60, 32'h1);
    chk(irq, 1'b1);
    wr32(32'h64, 32'h1);
    @(posedge hclk) clock_fail_detect <= 1'b1;
    @(posedge hclk) clock_fail_detect <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(irq, 1'b1);
    rd32(32'h68, rd); chk(rd, 32'h00040001);
    rd32(32'h68, rd); chk(rd, 32'h00000001);
    chk(irq, 1'b0);
    // Guard key handling.
    wr32(32'h80, 32'h1);
    chk(pump_current_sel, 32'h1);
    wr32(32'hE4, 32'h504D4201);
    chk(guard_on, 1'b0);
    wr32(32'hE4, 32'h504D4301);
    chk(guard_on, 1'b1);
    rd32(32'hE4, rd); chk(rd, 32'h1);
    wr32(32'hE4, 32'h00000000);
    chk(guard_on, 1'b1);
    // Every covered register refuses a write and reports its offset.
    foreach (gofs[i]) begin
      wr32(gofs[i], (gofs[i] == 32'h80) ? 32'h0 : 32'hFFFFFFFF);
      chk({sys_clk_en, main_freq_cfg, first_pll_cfg, master_clock_cfg, usb_clk_cfg,
        prog_clk_cfg, pump_current_sel}, {64'h0, 32'h3F00, 32'h1, 96'h0, 32'h1});
      rd32(32'hE8, rd); chk(rd, (gofs[i] << 8) | 32'h1);
    end
    rd32(32'hE8, rd); chk(rd, 32'h0);
    wr32(32'h6C, 32'h0);
    rd32(32'hE8, rd); chk(rd, 32'h0);
    wr32(32'hE4, 32'h504D4300);
    chk(guard_on, 1'b0);
    wr32(32'h80, 32'h0);
    chk(pump_current_sel, 32'h0);
    rd32(32'hE8, rd); chk(rd, 32'h0);
    // Peripheral clock control over all divisor codes and boundary indexes.
    foreach (idx[i]) begin
      dv = 2'(i);
      pw = (32'h1 << 28) | (32'(dv) << 16) | 32'h1000 | 32'(idx[i]);
      wr32(32'h10C, pw);
      chk(periph_en[idx[i]], 1'b1);
      chk(periph_div[2*idx[i] +: 2], can_div(idx[i]) ? dv : 2'h0);
      rd32(32'h10C, rd);
      chk(rd, (32'h1 << 28) | (32'(can_div(idx[i]) ? dv : 2'h0) << 16) | idx[i]);
    end
    wr32(32'h10C, 32'h00000002);
    rd32(32'h10C, rd); chk(rd, 32'h10020002);
    wr32(32'h10C, 32'h00000003);
    chk(periph_en[3], 1'b1);
    wr32(32'h10C, 32'h00011002);
    chk({periph_en[2], periph_div[5:4]}, 3'b001);
    // A frozen block must ignore a whole bus transfer.
    @(posedge hclk) clk_en <= 1'b0;
    wr32(32'h80, 32'h1);
    chk(pump_current_sel, 32'h0);
    @(posedge hclk) clk_en <= 1'b1;
    stop_test();
  end
endmodule
